// file: hw/srb_map.svh
// Constants for the SDRAM row-activate and read-burst block: register map, fields, pin codes, timing base.
// Assumes it is included by bare name from the design modules and the bench files; the package does not include it.
`ifndef SRB_MAP_SVH
`define SRB_MAP_SVH
// Clock period in ns
`define SRB_CLK_NS 10
// Register byte offsets
`define SRB_REG_CFG 8'h00
`define SRB_REG_STAT 8'h04
`define SRB_REG_VIOL 8'h08
// Configuration fields and reset value (latency 3, burst code 2)
`define SRB_CFG_CL_LSB 0
`define SRB_CFG_BL_LSB 2
`define SRB_CFG_RST 32'h0000_000B
`define SRB_BL_FULL 3'h7
// Address bit that selects auto precharge or all banks
`define SRB_AP_BIT 10
// Command codes on {ras_n, cas_n, we_n}
`define SRB_CMD_ACT 3'h3
`define SRB_CMD_RD 3'h5
`define SRB_CMD_WR 3'h4
`define SRB_CMD_PRE 3'h2
`define SRB_CMD_BST 3'h6
`define SRB_CMD_NOP 3'h7
// Sticky violation bit positions
`define SRB_V_RCD 0
`define SRB_V_ACT 1
`define SRB_V_RRD 2
`define SRB_V_CLOSED 3
`define SRB_V_WRINV 4
`define SRB_VIOL_W 5
// Width of the saturating spacing counters
`define SRB_CNT_W 8
`endif

// file: hw/srb_pkg.sv
// Types shared by the SDRAM row-activate and read-burst block.
// Uses no map header constants; pin and data widths are fixed literals here.
package srb_pkg;
  // Decoded command
  typedef enum logic [2:0] {OP_NOP, OP_ACT, OP_RD, OP_WR, OP_PRE, OP_BST, OP_OTHER} srb_op_t;
  // Command and address pins
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] ba;
    logic [12:0] addr;
  } srb_cmd_t;
  // One read data element in flight
  typedef struct packed {
    logic v;
    logic [15:0] d;
  } srb_elem_t;
endpackage : srb_pkg

// file: hw/srb_bank.sv
// One bank: open row, row address and command spacing checks.
// Assumes decoded one-cycle command strobes from the top module.
`timescale 1ns/100ps
`default_nettype none
`include "srb_map.svh"
module srb_bank #(
  parameter int ACTIVATE_TO_COLUMN_DELAY_CYC = 2,
  parameter int TRC_CYC = 6,
  parameter int TRP_CYC = 2,
  parameter int ROW_W = 2
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic act,
  input wire logic pre,
  input wire logic acc,
  input wire logic [ROW_W-1:0] row_in,
  output logic is_open,
  output logic [ROW_W-1:0] row,
  output logic bad_rcd,
  output logic bad_act,
  output logic bad_closed
);
  import srb_pkg::*;
  localparam int CW = `SRB_CNT_W;
  localparam logic [CW-1:0] CMAX = '1;
  localparam logic [CW-1:0] RCD = CW'(ACTIVATE_TO_COLUMN_DELAY_CYC);
  localparam logic [CW-1:0] RC = CW'(TRC_CYC);
  localparam logic [CW-1:0] RP = CW'(TRP_CYC);

  if (ACTIVATE_TO_COLUMN_DELAY_CYC < 1 || TRC_CYC < 1 || TRP_CYC < 1 || TRC_CYC > 255 || ACTIVATE_TO_COLUMN_DELAY_CYC > 255 || TRP_CYC > 255) begin : g_chk
    $error("srb_bank: spacing count out of range");
  end

  logic open_r, open_nxt;
  logic [ROW_W-1:0] row_r, row_nxt;
  logic [CW-1:0] since_act_r, since_act_nxt, since_pre_r, since_pre_nxt;

  // Row open and close, cycles since last activate and precharge
  always_comb begin
    open_nxt = open_r;
    row_nxt = row_r;
    since_act_nxt = (since_act_r == CMAX) ? CMAX : since_act_r + 1'b1;
    since_pre_nxt = (since_pre_r == CMAX) ? CMAX : since_pre_r + 1'b1;
    if (act && !open_r) begin
      open_nxt = 1'b1;
      row_nxt = row_in;
      since_act_nxt = CW'(1);
    end
    if (pre) begin
      open_nxt = 1'b0;
      since_pre_nxt = CW'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      open_r <= 1'b0;
      row_r <= '0;
      since_act_r <= '1;
      since_pre_r <= '1;
    end else begin
      open_r <= open_nxt;
      row_r <= row_nxt;
      since_act_r <= since_act_nxt;
      since_pre_r <= since_pre_nxt;
    end
  end

  // Spacing and row-state violations seen by this bank
  assign bad_rcd = acc && open_r && (since_act_r < RCD);
  assign bad_closed = acc && !open_r;
  assign bad_act = act && (open_r || since_act_r < RC || since_pre_r < RP);
  assign is_open = open_r;
  assign row = row_r;
endmodule : srb_bank
`default_nettype wire

// file: hw/srb_top.sv
// SDRAM device core: row activation, read bursts and their truncation, APB status and config.
// Assumes command, mask and data pins are synchronous to MCLK; the bench resolves DQ from DQ_O and DQ_OE.
// Functional notes
// - Other banks may be activated meanwhile, separated by the bank-to-bank gap.
// - Read with auto precharge closes the row when the burst completes.
// - First data appears cas_latency after READ, then one element per cycle.
// - Data pins go high-impedance when a burst completes with no new command.
// - Full-page bursts run on, wrapping to the start column at page end.
// - A new READ continues data without gap, issued cas_latency minus one early.
// - READ is accepted every cycle, to any open bank.
// - WRITE may cut a read burst right after the last wanted element.
// - After a cutting WRITE pins stay high-impedance if mask was high before.
// - PRECHARGE may cut a fixed burst, issued cas_latency minus one early.
// - BURST TERMINATE ends a burst, issued cas_latency minus one early.
// - A mask bit registered high blanks its byte two clocks later.
// - The auto precharge bit decides whether the row stays open after fixed-length READs; WRITE and full-page READs ignore it.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "srb_map.svh"
module srb_top #(
  parameter int ACTIVATE_TO_COLUMN_DELAY_NS = 20,
  parameter int TRC_NS = 60,
  parameter int BANK_TO_BANK_ACTIVATE_GAP_NS = 20,
  parameter int TRP_NS = 20,
  parameter int COL_W = 4,
  parameter int ROW_W = 2
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire srb_pkg::srb_cmd_t CMD,
  input wire logic [1:0] DQM,
  input wire logic [15:0] DQ_I,
  output logic [15:0] DQ_O,
  output logic [1:0] DQ_OE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  import srb_pkg::*;
  localparam int ACTIVATE_TO_COLUMN_DELAY_CYC = (ACTIVATE_TO_COLUMN_DELAY_NS + `SRB_CLK_NS - 1) / `SRB_CLK_NS;
  localparam int TRC_CYC = (TRC_NS + `SRB_CLK_NS - 1) / `SRB_CLK_NS;
  localparam int BANK_TO_BANK_ACTIVATE_GAP_CYC = (BANK_TO_BANK_ACTIVATE_GAP_NS + `SRB_CLK_NS - 1) / `SRB_CLK_NS;
  localparam int TRP_CYC = (TRP_NS + `SRB_CLK_NS - 1) / `SRB_CLK_NS;
  localparam int AW = 2 + ROW_W + COL_W;
  localparam int CW = `SRB_CNT_W;

  if (COL_W < 3 || COL_W > 9 || ROW_W < 1 || ROW_W > 4 || ACTIVATE_TO_COLUMN_DELAY_NS < 1 || TRC_NS < 1 || BANK_TO_BANK_ACTIVATE_GAP_NS < 1
      || TRP_NS < 1 || BANK_TO_BANK_ACTIVATE_GAP_CYC > 255) begin : g_chk
    $error("srb_top: parameter out of range");
  end

  // Reset release through two flip-flops
  logic rst_meta_r, rst_n;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // Command decode; refresh and mode loads fall to OP_OTHER
  srb_op_t op;
  always_comb begin
    op = OP_NOP;
    if (!CMD.cs_n) begin
      unique case ({CMD.ras_n, CMD.cas_n, CMD.we_n})
        `SRB_CMD_ACT: op = OP_ACT;
        `SRB_CMD_RD: op = OP_RD;
        `SRB_CMD_WR: op = OP_WR;
        `SRB_CMD_PRE: op = OP_PRE;
        `SRB_CMD_BST: op = OP_BST;
        `SRB_CMD_NOP: op = OP_NOP;
        default: op = OP_OTHER;
      endcase
    end
  end

  logic [1:0] cl_r, cl_nxt;
  logic [2:0] bl_r, bl_nxt;
  logic gen_v_r, gen_v_nxt, full_r, full_nxt, ap_r, ap_nxt, apre;
  logic [1:0] gen_bank_r, gen_bank_nxt;
  logic [ROW_W-1:0] gen_row_r, gen_row_nxt;
  logic [COL_W-1:0] gen_col_r, gen_col_nxt, start_col_r, start_col_nxt, left_r, left_nxt, mask;
  logic [3:0] bank_open, bad_rcd, bad_act, bad_closed;
  logic [ROW_W-1:0] bank_row [4];
  logic rd_ok, stop_now;

  // Four banks, each with its own row and spacing state
  for (genvar b = 0; b < 4; b++) begin : g_bank
    srb_bank #(.ACTIVATE_TO_COLUMN_DELAY_CYC(ACTIVATE_TO_COLUMN_DELAY_CYC), .TRC_CYC(TRC_CYC), .TRP_CYC(TRP_CYC), .ROW_W(ROW_W)) u_bank (
      .clk(MCLK),
      .rst_n(rst_n),
      .act(op == OP_ACT && CMD.ba == 2'(b)),
      .pre((op == OP_PRE && (CMD.addr[`SRB_AP_BIT] || CMD.ba == 2'(b))) || (apre && gen_bank_r == 2'(b))),
      .acc((op == OP_RD || op == OP_WR) && CMD.ba == 2'(b)),
      .row_in(CMD.addr[ROW_W-1:0]),
      .is_open(bank_open[b]),
      .row(bank_row[b]),
      .bad_rcd(bad_rcd[b]),
      .bad_act(bad_act[b]),
      .bad_closed(bad_closed[b])
    );
  end

  // Bank-to-bank activate gap across all banks
  logic [1:0] last_act_bank_r;
  logic [CW-1:0] since_any_r, since_any_nxt;
  logic bad_rrd;
  assign bad_rrd = op == OP_ACT && CMD.ba != last_act_bank_r && since_any_r < CW'(BANK_TO_BANK_ACTIVATE_GAP_CYC);
  always_comb begin
    since_any_nxt = (since_any_r == '1) ? since_any_r : since_any_r + 1'b1;
    if (op == OP_ACT) since_any_nxt = CW'(1);
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      since_any_r <= '1;
      last_act_bank_r <= 2'h0;
    end else begin
      since_any_r <= since_any_nxt;
      last_act_bank_r <= (op == OP_ACT) ? CMD.ba : last_act_bank_r;
    end
  end

  // Burst generator: one column address per cycle
  assign mask = (bl_r == `SRB_BL_FULL) ? '1 : COL_W'((1 << bl_r) - 1);
  assign rd_ok = op == OP_RD && bank_open[CMD.ba];
  assign stop_now = op == OP_WR || op == OP_BST
                    || (op == OP_PRE && (CMD.addr[`SRB_AP_BIT] || CMD.ba == gen_bank_r));
  always_comb begin
    gen_v_nxt = gen_v_r;
    gen_bank_nxt = gen_bank_r;
    gen_row_nxt = gen_row_r;
    gen_col_nxt = gen_col_r;
    start_col_nxt = start_col_r;
    left_nxt = left_r;
    full_nxt = full_r;
    ap_nxt = ap_r;
    apre = 1'b0;
    if (rd_ok) begin
      gen_v_nxt = 1'b1;
      gen_bank_nxt = CMD.ba;
      gen_row_nxt = bank_row[CMD.ba];
      gen_col_nxt = CMD.addr[COL_W-1:0];
      start_col_nxt = CMD.addr[COL_W-1:0];
      left_nxt = mask;
      full_nxt = bl_r == `SRB_BL_FULL;
      ap_nxt = CMD.addr[`SRB_AP_BIT] && bl_r != `SRB_BL_FULL;
    end else if (gen_v_r) begin
      if (stop_now) begin
        gen_v_nxt = 1'b0;
      end else if (!full_r && left_r == '0) begin
        gen_v_nxt = 1'b0;
        apre = ap_r;
      end else if (full_r) begin
        gen_col_nxt = (gen_col_r == '1) ? start_col_r : gen_col_r + 1'b1;
      end else begin
        left_nxt = left_r - 1'b1;
        gen_col_nxt = (gen_col_r & ~mask) | ((gen_col_r + 1'b1) & mask);
      end
    end
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      gen_v_r <= 1'b0;
      gen_bank_r <= 2'h0;
      gen_row_r <= '0;
      gen_col_r <= '0;
      start_col_r <= '0;
      left_r <= '0;
      full_r <= 1'b0;
      ap_r <= 1'b0;
    end else begin
      gen_v_r <= gen_v_nxt;
      gen_bank_r <= gen_bank_nxt;
      gen_row_r <= gen_row_nxt;
      gen_col_r <= gen_col_nxt;
      start_col_r <= start_col_nxt;
      left_r <= left_nxt;
      full_r <= full_nxt;
      ap_r <= ap_nxt;
    end
  end

  // Storage array; a write stores only the element given with the command
  logic [15:0] mem [1 << AW];
  logic [15:0] rdata, wmerge;
  logic [AW-1:0] waddr;
  logic wr_now, rd_busy, wr_bad;
  srb_elem_t mid_r, mid_nxt, src;
  logic [1:0] dqm_d1_r, oe_nxt;
  assign rdata = mem[{gen_bank_r, gen_row_r, gen_col_r}];
  assign waddr = {CMD.ba, bank_row[CMD.ba], CMD.addr[COL_W-1:0]};
  assign wr_now = op == OP_WR;
  assign rd_busy = gen_v_r || mid_r.v || (|DQ_OE);
  assign wr_bad = wr_now && rd_busy && dqm_d1_r != 2'b11;
  always_ff @(posedge MCLK) begin
    if (wr_now && bank_open[CMD.ba] && !wr_bad) mem[waddr] <= wmerge;
  end

  // Output pipeline: latency stage, mask delay and per-byte drive
  assign src = (cl_r == 2'd2) ? srb_elem_t'{v: gen_v_r, d: rdata} : mid_r;
  for (genvar b = 0; b < 2; b++) begin : g_byte
    assign oe_nxt[b] = src.v && !dqm_d1_r[b] && !wr_now;
    assign wmerge[b*8 +: 8] = DQM[b] ? mem[waddr][b*8 +: 8] : DQ_I[b*8 +: 8];
  end
  always_comb begin
    mid_nxt.v = gen_v_r && !wr_now;
    mid_nxt.d = rdata;
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      mid_r <= '0;
      dqm_d1_r <= 2'b00;
      DQ_O <= 16'h0000;
      DQ_OE <= 2'b00;
    end else begin
      mid_r <= mid_nxt;
      dqm_d1_r <= DQM;
      DQ_O <= src.d;
      DQ_OE <= oe_nxt;
    end
  end

  // APB slave: one wait-free access phase, sticky violations with set over clear
  logic [`SRB_VIOL_W-1:0] viol_r, viol_nxt, viol_set;
  logic [31:0] prdata_nxt;
  logic setup, acc_wr, known;
  assign setup = PSEL && !PENABLE;
  assign acc_wr = PSEL && PENABLE && PREADY && PWRITE;
  assign known = PADDR == `SRB_REG_CFG || PADDR == `SRB_REG_STAT || PADDR == `SRB_REG_VIOL;
  assign viol_set = {wr_bad, |bad_closed, bad_rrd, |bad_act, |bad_rcd};
  always_comb begin
    cl_nxt = cl_r;
    bl_nxt = bl_r;
    viol_nxt = viol_r;
    prdata_nxt = 32'h0000_0000;
    if (setup) begin
      unique case (PADDR)
        `SRB_REG_CFG: prdata_nxt = {27'h0, bl_r, cl_r};
        `SRB_REG_STAT: prdata_nxt = {26'h0, |DQ_OE, gen_v_r, bank_open};
        `SRB_REG_VIOL: prdata_nxt = {27'h0, viol_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (acc_wr && PADDR == `SRB_REG_CFG) begin
      if (PWDATA[`SRB_CFG_CL_LSB + 1]) cl_nxt = PWDATA[`SRB_CFG_CL_LSB +: 2];
      if (!PWDATA[`SRB_CFG_BL_LSB + 2] || PWDATA[`SRB_CFG_BL_LSB +: 3] == `SRB_BL_FULL)
        bl_nxt = PWDATA[`SRB_CFG_BL_LSB +: 3];
    end
    if (acc_wr && PADDR == `SRB_REG_VIOL) viol_nxt = viol_r & ~PWDATA[`SRB_VIOL_W-1:0];
    viol_nxt = viol_nxt | viol_set;
  end
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      cl_r <= 2'(`SRB_CFG_RST >> `SRB_CFG_CL_LSB);
      bl_r <= 3'(`SRB_CFG_RST >> `SRB_CFG_BL_LSB);
      viol_r <= '0;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      cl_r <= cl_nxt;
      bl_r <= bl_nxt;
      viol_r <= viol_nxt;
      PRDATA <= prdata_nxt;
      PREADY <= setup;
      PSLVERR <= setup && !known;
    end
  end

  // Checks on the read path
  chk_wr_hiz: assert property (@(posedge MCLK) disable iff (!rst_n) op == OP_WR |=> DQ_OE == 2'b00)
    else $error("data pins driven after write");
  chk_dqm_lat: assert property (@(posedge MCLK) disable iff (!rst_n) DQM[0] |-> ##2 !DQ_OE[0])
    else $error("masked byte driven two clocks later");
  chk_cl2_first: assert property (@(posedge MCLK) disable iff (!rst_n)
    (rd_ok && cl_r == 2'd2 && DQM == 2'b00) ##1 (op != OP_WR) |-> ##1 DQ_OE == 2'b11)
    else $error("first element missing at latency two");
  chk_cl3_first: assert property (@(posedge MCLK) disable iff (!rst_n)
    (rd_ok && cl_r == 2'd3 && !gen_v_r && !mid_r.v) ##1 (op != OP_WR && DQM == 2'b00) ##1 (op != OP_WR)
    |-> !DQ_OE[0] ##1 DQ_OE == 2'b11)
    else $error("first element wrong at latency three");
  chk_burst_two: assert property (@(posedge MCLK) disable iff (!rst_n)
    (rd_ok && bl_r == 3'h1) ##1 (op == OP_NOP) ##1 (op == OP_NOP) |-> gen_v_r ##1 !gen_v_r)
    else $error("burst of two has wrong length");
  chk_auto_pre: assert property (@(posedge MCLK) disable iff (!rst_n)
    (rd_ok && bl_r == 3'h0 && CMD.addr[`SRB_AP_BIT]) ##1 (op == OP_NOP) |-> ##1 !bank_open[$past(CMD.ba, 2)])
    else $error("auto precharge did not close the row");
  chk_keep_open: assert property (@(posedge MCLK) disable iff (!rst_n)
    (rd_ok && bl_r == 3'h0 && !CMD.addr[`SRB_AP_BIT]) ##1 (op == OP_NOP) |-> ##1 bank_open[$past(CMD.ba, 2)])
    else $error("row closed without auto precharge");
  chk_gapless: assert property (@(posedge MCLK) disable iff (!rst_n) rd_ok |=> gen_v_r)
    else $error("read not accepted");
  chk_stop_cmd: assert property (@(posedge MCLK) disable iff (!rst_n)
    gen_v_r && (op == OP_BST || (op == OP_PRE && CMD.ba == gen_bank_r)) |=> !gen_v_r)
    else $error("burst not stopped");
  chk_hiz_idle: assert property (@(posedge MCLK) disable iff (!rst_n)
    !gen_v_r && !mid_r.v |=> DQ_OE == 2'b00)
    else $error("pins driven with no burst");
  chk_page_wrap: assert property (@(posedge MCLK) disable iff (!rst_n)
    gen_v_r && full_r && gen_col_r == '1 && op == OP_NOP |=> gen_v_r && gen_col_r == $past(start_col_r))
    else $error("full page did not wrap");
endmodule : srb_top
`default_nettype wire

// file: tb/srb_ctl_model.sv
// Memory controller model facing the SDRAM core: drives command, mask and write data pins.
// Assumes one send call per clock cycle from the bench, which sets the command schedule.
`timescale 1ns/100ps
`default_nettype none
`include "srb_map.svh"
module srb_ctl_model (
  input wire logic clk,
  output srb_pkg::srb_cmd_t cmd,
  output logic [1:0] dqm,
  output logic [15:0] dq_i,
  input wire logic [15:0] dq_o,
  input wire logic [1:0] dq_oe
);
  import srb_pkg::*;
  logic [15:0] wd;
  logic drv;
  logic [15:0] last_r;
  // Wire per byte: device data, else write data, else a changing idle pattern
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      dq_i[b*8 +: 8] = dq_oe[b] ? dq_o[b*8 +: 8] : (drv ? wd[b*8 +: 8] : ~last_r[b*8 +: 8]);
    end
  end
  // Remember the last wire level so a released bus never repeats it
  always @(posedge clk) begin
    last_r <= dq_i;
  end
  initial begin
    cmd = srb_cmd_t'({1'b0, `SRB_CMD_NOP, 2'h0, 13'h0000});
    dqm = 2'h0;
    wd = 16'h0000;
    drv = 1'b0;
    last_r = 16'h0000;
  end
  // Command, mask and data change together after the edge; ACT, column and precharge
  // spacing comes from the caller's schedule
  task send(input srb_cmd_t c, input logic [1:0] m, input logic [15:0] d);
    @(posedge clk);
    cmd <= c;
    dqm <= m;
    wd <= d;
    drv <= !c.cs_n && ({c.ras_n, c.cas_n, c.we_n} == `SRB_CMD_WR);
  endtask : send
endmodule : srb_ctl_model
`default_nettype wire

// file: tb/tb_sdram_row_activate_read_burst.sv
// Self-checking bench for the SDRAM row-activate and read-burst core.
// Assumes the controller model drives the memory pins and the bench drives APB.
`timescale 1ns/100ps
`default_nettype none
`include "srb_map.svh"
module tb_sdram_row_activate_read_burst;
  import srb_pkg::*;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  srb_cmd_t cmd;
  logic [1:0] dqm, dq_oe;
  logic [15:0] dq_i, dq_o;
  int fail_count = 0;
  int checks = 0;
  srb_cmd_t cq[64];
  logic [1:0] mq[64], eq[64];
  logic [15:0] wq[64], dq[64], mem_exp[16];

  srb_top uut (.MCLK(mclk), .RESETN(resetn), .CMD(cmd), .DQM(dqm), .DQ_I(dq_i), .DQ_O(dq_o),
    .DQ_OE(dq_oe), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  srb_ctl_model ctl (.clk(mclk), .cmd(cmd), .dqm(dqm), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));

  always #5 mclk = ~mclk;

  function automatic srb_cmd_t mk(input logic [2:0] op, input logic [1:0] ba, input logic [12:0] a);
    return srb_cmd_t'({1'b0, op, ba, a});
  endfunction : mk

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // APB transfer, holding the request until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] ex, input logic ee);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    cmp({31'h0, pready}, 32'h0000_0001);
    if (!w) cmp(prdata, ex);
    cmp({31'h0, pslverr}, {31'h0, ee});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Empty schedule: NOP, mask low, pins released
  task clr();
    for (int i = 0; i < 64; i++) begin
      cq[i] = mk(`SRB_CMD_NOP, 2'h0, 13'h0000);
      mq[i] = 2'h0;
      eq[i] = 2'h0;
      wq[i] = 16'h0000;
      dq[i] = 16'h0000;
    end
  endtask : clr

  // READ to bank 0 at cycle t; n elements expected from t+cl, wrapping inside bl
  task rd(input int t, input int col, input logic ap, input int n, input int cl, input int bl);
    cq[t] = mk(`SRB_CMD_RD, 2'h0, {2'h0, ap, 6'h00, 4'(col)});
    for (int k = 0; k < n; k++) begin
      eq[t + cl + k] = 2'h3;
      dq[t + cl + k] = mem_exp[(col & ~(bl - 1)) | ((col + k) & (bl - 1))];
    end
  endtask : rd

  // Play the schedule, checking enables and unmasked data in every cycle
  task run(input int n);
    logic [15:0] bm;
    for (int i = 0; i < n; i++) begin
      ctl.send(cq[i], mq[i], wq[i]);
      @(negedge mclk);
      bm = {{8{eq[i][1]}}, {8{eq[i][0]}}};
      cmp({30'h0, dq_oe}, {30'h0, eq[i]});
      cmp({16'h0, dq_o & bm}, {16'h0, dq[i] & bm});
    end
  endtask : run

  // Register values after reset, read-only status and an unmapped address
  task s_regs();
    apb(1'b0, `SRB_REG_CFG, 32'h0, 32'h0000_000B, 1'b0);
    apb(1'b1, `SRB_REG_STAT, 32'h0000_001F, 32'h0, 1'b0);
    apb(1'b0, `SRB_REG_STAT, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, `SRB_REG_VIOL, 32'h0, 32'h0000_0000, 1'b0);
    apb(1'b0, 8'h0C, 32'h0, 32'h0000_0000, 1'b1);
  endtask : s_regs

  // Open two banks, fill a page, then one burst at latency 3
  task s_fill();
    clr();
    cq[0] = mk(`SRB_CMD_ACT, 2'h0, 13'h0001);
    cq[2] = mk(`SRB_CMD_ACT, 2'h1, 13'h0000);
    for (int k = 0; k < 16; k++) begin
      mem_exp[k] = 16'hC000 | (16'(k) * 16'h0101);
      cq[3 + k] = mk(`SRB_CMD_WR, 2'h0, 13'(k));
      wq[3 + k] = mem_exp[k];
    end
    rd(20, 5, 1'b0, 4, 3, 4);
    run(30);
    apb(1'b0, `SRB_REG_STAT, 32'h0, 32'h0000_0003, 1'b0);
  endtask : s_fill

  // Latency 2: back-to-back and cutting READs give gapless data
  task s_reread();
    apb(1'b1, `SRB_REG_CFG, 32'h0000_000A, 32'h0, 1'b0);
    clr();
    rd(0, 0, 1'b0, 2, 2, 4);
    rd(2, 8, 1'b0, 4, 2, 4);
    rd(6, 12, 1'b0, 1, 2, 4);
    rd(7, 5, 1'b0, 4, 2, 4);
    run(16);
  endtask : s_reread

  // Mask blanks bytes two cycles on; a WRITE cuts the burst and is stored
  task s_mask();
    clr();
    rd(0, 0, 1'b0, 4, 2, 4);
    mq[1] = 2'h1;
    eq[3] = 2'h2;
    mq[3] = 2'h3;
    mq[4] = 2'h3;
    eq[5] = 2'h0;
    cq[5] = mk(`SRB_CMD_WR, 2'h0, 13'h0002);
    wq[5] = 16'h1234;
    mem_exp[2] = 16'h1234;
    rd(8, 2, 1'b0, 4, 2, 4);
    run(16);
    apb(1'b0, `SRB_REG_VIOL, 32'h0, 32'h0000_0000, 1'b0);
  endtask : s_mask

  // Full page wraps to the start column until BURST TERMINATE
  task s_page();
    apb(1'b1, `SRB_REG_CFG, 32'h0000_001E, 32'h0, 1'b0);
    clr();
    rd(0, 3, 1'b0, 13, 2, 16);
    // Past the last column the burst resumes at the start column
    for (int k = 0; k < 5; k++) begin
      eq[15 + k] = 2'h3;
      dq[15 + k] = mem_exp[3 + k];
    end
    cq[18] = mk(`SRB_CMD_BST, 2'h0, 13'h0000);
    run(24);
  endtask : s_page

  // Bursts of one, two and eight, auto precharge, reopening and spacing faults
  task s_short();
    apb(1'b1, `SRB_REG_CFG, 32'h0000_0002, 32'h0, 1'b0);
    clr();
    rd(0, 3, 1'b0, 1, 2, 1);
    rd(4, 6, 1'b1, 1, 2, 1);
    cq[8] = mk(`SRB_CMD_ACT, 2'h0, 13'h0001);
    rd(9, 0, 1'b0, 1, 2, 1);
    cq[10] = mk(`SRB_CMD_ACT, 2'h0, 13'h0001);
    cq[11] = mk(`SRB_CMD_ACT, 2'h2, 13'h0000);
    cq[14] = mk(`SRB_CMD_PRE, 2'h2, 13'h0000);
    run(16);
    apb(1'b0, `SRB_REG_VIOL, 32'h0, 32'h0000_0007, 1'b0);
    apb(1'b1, `SRB_REG_VIOL, 32'h0000_0007, 32'h0, 1'b0);
    apb(1'b1, `SRB_REG_CFG, 32'h0000_0006, 32'h0, 1'b0);
    clr();
    rd(0, 1, 1'b0, 2, 2, 2);
    run(6);
    apb(1'b1, `SRB_REG_CFG, 32'h0000_000E, 32'h0, 1'b0);
    clr();
    rd(0, 10, 1'b0, 8, 2, 8);
    run(12);
  endtask : s_short

  // PRECHARGE cut, auto precharge closing the row, refused READ to a closed bank
  task s_close();
    apb(1'b1, `SRB_REG_CFG, 32'h0000_000A, 32'h0, 1'b0);
    clr();
    rd(0, 4, 1'b0, 2, 2, 4);
    cq[2] = mk(`SRB_CMD_PRE, 2'h0, 13'h0000);
    cq[5] = mk(`SRB_CMD_ACT, 2'h0, 13'h0001);
    rd(7, 8, 1'b1, 4, 2, 4);
    cq[16] = mk(`SRB_CMD_RD, 2'h0, 13'h0000);
    run(22);
    apb(1'b0, `SRB_REG_VIOL, 32'h0, 32'h0000_0008, 1'b0);
    apb(1'b0, `SRB_REG_STAT, 32'h0, 32'h0000_0002, 1'b0);
    apb(1'b1, `SRB_REG_VIOL, 32'h0000_0008, 32'h0, 1'b0);
    apb(1'b0, `SRB_REG_VIOL, 32'h0, 32'h0000_0000, 1'b0);
  endtask : s_close

  task print_verdict();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    s_regs();
    s_fill();
    s_reread();
    s_mask();
    s_page();
    s_short();
    s_close();
    print_verdict();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
endmodule : tb_sdram_row_activate_read_burst
`default_nettype wire
